/* File: hw/pcc_carrier.sv */
`include "pcc_consts.svh"
`default_nettype none

module pcc_carrier
  import pcc_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // Settings
  input wire logic [2:0] freq_sel,
  input wire logic [2:0] duty_sel,
  // Carrier and phase
  output logic carrier,
  output logic [2:0] eighth
);

  pcc_car_s r_reg;
  pcc_car_s r_next;
  logic [2:0] duty_eff;

  // Reserved full-duty code clamps to 7/8
  assign duty_eff = (duty_sel > `PCC_DUTY_MAX) ? `PCC_DUTY_MAX : duty_sel;

  // Prescale by freq_sel+1, then step one eighth of the period
  always_comb begin
    r_next = r_reg;
    if (r_reg.pre_cnt >= freq_sel) begin
      r_next.pre_cnt = 3'h0;
      r_next.eighth = r_reg.eighth + 3'h1;
    end else begin
      r_next.pre_cnt = r_reg.pre_cnt + 3'h1;
    end
    r_next.carrier = (r_reg.eighth <= duty_eff);
  end

  // State register
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign carrier = r_reg.carrier;
  assign eighth = r_reg.eighth;

  a_phase_step: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (!$past(sys_rst) && (r_reg.eighth != $past(r_reg.eighth)))
      |-> ($past(r_reg.pre_cnt) >= $past(freq_sel)))
    else $error("carrier phase stepped before prescale end");

  a_never_full: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (r_reg.eighth == `PCC_LAST_EIGHTH) |=> !r_reg.carrier)
    else $error("carrier high in last eighth");

  a_duty_low: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (r_reg.eighth > duty_eff) |=> !r_reg.carrier)
    else $error("carrier high past duty");

endmodule

`default_nettype wire

/* File: hw/pcc_chopper.sv */
// Chosen here: the APB slave port.
`include "pcc_consts.svh"
`default_nettype none

module pcc_chopper
  import pcc_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // PWM from the dead-band stage
  input wire logic pwm_in_a,
  input wire logic pwm_in_b,
  // Chopped PWM toward the trip stage
  output logic pwm_out_a,
  output logic pwm_out_b
);

  pcc_chop_s r_reg;
  pcc_chop_s r_next;

  logic chopper_on;
  logic [3:0] first_pulse_width;
  logic [2:0] carrier_freq_sel;
  logic [2:0] sustain_duty_sel;
  logic carrier;
  logic [2:0] eighth;
  logic [7:0] fp_total;
  logic [1:0] pwm_in;
  logic [1:0] rise;
  logic [1:0] os_now;
  logic [1:0] out_val;
  logic setup_ph;
  logic access_ph;
  logic hit_ctrl;
  logic hit_stat;
  logic [31:0] stat_word;

  // Register address match, used by the read and write paths
  function automatic logic addr_hit(input logic [11:0] addr, input logic [11:0] idx);
    addr_hit = (addr == {idx[9:0], 2'b00});
  endfunction

  // Control fields, live without any shadow
  assign chopper_on = r_reg.ctrl[`PCC_ON_BIT];
  assign first_pulse_width = r_reg.ctrl[`PCC_FPW_MSB:`PCC_FPW_LSB];
  assign carrier_freq_sel = r_reg.ctrl[`PCC_FREQ_MSB:`PCC_FREQ_LSB];
  assign sustain_duty_sel = r_reg.ctrl[`PCC_DUTY_MSB:`PCC_DUTY_LSB];

  // First pulse length in clocks, 8 to 128
  assign fp_total = 8'(({4'h0, first_pulse_width} + 8'h01) * `PCC_FP_CLKS);

  assign pwm_in = {pwm_in_b, pwm_in_a};

  // Carrier source
  pcc_carrier u_carrier (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .freq_sel(carrier_freq_sel),
    .duty_sel(sustain_duty_sel),
    .carrier(carrier),
    .eighth(eighth)
  );

  // Per-channel edge detect, one-shot window and output select
  for (genvar ch = 0; ch < 2; ch++) begin : g_chan
    assign rise[ch] = pwm_in[ch] & ~r_reg.pwm_prev[ch];
    assign os_now[ch] = rise[ch] | (r_reg.os_cnt[ch] > 8'h01);
    assign out_val[ch] = chopper_on
      ? (pwm_in[ch] & (os_now[ch] | carrier))
      : pwm_in[ch];
  end

  // Bus phase decode
  assign setup_ph = psel & ~penable;
  assign access_ph = psel & penable;
  assign hit_ctrl = addr_hit(paddr, `PCC_CTRL_IDX);
  assign hit_stat = addr_hit(paddr, `PCC_STAT_IDX);

  // Read-only status view
  always_comb begin
    stat_word = 32'h0000_0000;
    stat_word[`PCC_ST_OUT_A] = r_reg.out[0];
    stat_word[`PCC_ST_OUT_B] = r_reg.out[1];
    stat_word[`PCC_ST_CARRIER] = carrier;
    stat_word[`PCC_ST_OS_A] = (r_reg.os_cnt[0] != 8'h00);
    stat_word[`PCC_ST_OS_B] = (r_reg.os_cnt[1] != 8'h00);
  end

  // Next state
  always_comb begin
    r_next = r_reg;
    r_next.pwm_prev = pwm_in;
    // One-shot counters restart on each PWM rise, cleared when PWM is low
    for (int i = 0; i < 2; i++) begin
      if (!pwm_in[i]) begin
        r_next.os_cnt[i] = 8'h00;
      end else if (rise[i]) begin
        r_next.os_cnt[i] = fp_total;
      end else if (r_reg.os_cnt[i] != 8'h00) begin
        r_next.os_cnt[i] = r_reg.os_cnt[i] - 8'h01;
      end
    end
    r_next.out = out_val;
    // Read data and error captured in the setup cycle
    if (setup_ph) begin
      if (hit_ctrl) begin
        r_next.prdata = {16'h0000, r_reg.ctrl};
        r_next.pslverr = 1'b0;
      end else if (hit_stat) begin
        r_next.prdata = stat_word;
        r_next.pslverr = 1'b0;
      end else begin
        r_next.prdata = 32'h0000_0000;
        r_next.pslverr = 1'b1;
      end
    end
    // Writes land at the access cycle, byte lanes honoured
    if (access_ph && pwrite && hit_ctrl) begin
      if (pstrb[0]) begin
        r_next.ctrl[7:0] = pwdata[7:0];
      end
      if (pstrb[1]) begin
        r_next.ctrl[15:8] = pwdata[15:8];
      end
    end
  end

  // State register
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      r_reg <= '0;
      r_reg.ctrl <= `PCC_CTRL_RST;
    end else begin
      r_reg <= r_next;
    end
  end

  // Zero-wait slave; pready decoded from psel and penable, other outputs from flip-flops
  assign pready = access_ph;
  assign prdata = r_reg.prdata;
  assign pslverr = r_reg.pslverr;
  assign pwm_out_a = r_reg.out[0];
  assign pwm_out_b = r_reg.out[1];

  // Helper: previous-cycle view of inputs and settings
  logic [1:0] in_d;
  logic on_d;
  logic car_d;
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      in_d <= 2'b00;
      on_d <= 1'b0;
      car_d <= 1'b0;
    end else begin
      in_d <= pwm_in;
      on_d <= chopper_on;
      car_d <= carrier;
    end
  end

  // Sequences for the first pulse and the control write
  sequence s_rise_a;
    chopper_on && pwm_in_a && !r_reg.pwm_prev[0];
  endsequence

  sequence s_hold_a;
    chopper_on && pwm_in_a && (r_reg.os_cnt[0] > 8'h01);
  endsequence

  sequence s_ctrl_write;
    psel && penable && pwrite && hit_ctrl && (pstrb[1:0] == 2'b11);
  endsequence

  a_bypass_pass: assert property (@(posedge clk_sys) disable iff (sys_rst)
    !chopper_on |=> (r_reg.out == in_d))
    else $error("bypass output differs from input");

  a_and_gate: assert property (@(posedge clk_sys) disable iff (sys_rst)
    ##1 (r_reg.out != 2'b00) |-> ((r_reg.out & ~in_d) == 2'b00))
    else $error("output high while input low");

  a_low_follow: assert property (@(posedge clk_sys) disable iff (sys_rst)
    !pwm_in_a |=> !pwm_out_a)
    else $error("output a not low one cycle after input low");

  a_first_load: assert property (@(posedge clk_sys) disable iff (sys_rst)
    s_rise_a |=> (r_reg.os_cnt[0] == 8'(({4'h0, $past(first_pulse_width)} + 8'h01) * 8)))
    else $error("first pulse length not eight per step");

  a_first_span: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (r_reg.os_cnt[0] <= 8'h80) && (r_reg.os_cnt[1] <= 8'h80))
    else $error("first pulse count beyond sixteen steps");

  a_first_high: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (s_rise_a or s_hold_a) |=> pwm_out_a)
    else $error("output a low inside first pulse");

  a_chop_gap: assert property (@(posedge clk_sys) disable iff (sys_rst)
    ##1 (on_d && in_d[0] && !car_d && (r_reg.os_cnt[0] == 8'h00)) |-> !pwm_out_a)
    else $error("output a high outside carrier pulse");

  a_ctrl_direct: assert property (@(posedge clk_sys) disable iff (sys_rst)
    s_ctrl_write |=> (r_reg.ctrl == $past(pwdata[15:0])))
    else $error("control write not applied next cycle");

  a_unmapped_err: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (psel && !penable && !hit_ctrl && !hit_stat) |=> (pslverr && prdata == 32'h0000_0000))
    else $error("unmapped access without error");

  // Channel b mirrors the first-pulse and gap checks
  sequence s_rise_b;
    chopper_on && pwm_in_b && !r_reg.pwm_prev[1];
  endsequence

  sequence s_hold_b;
    chopper_on && pwm_in_b && (r_reg.os_cnt[1] > 8'h01);
  endsequence

  a_low_follow_b: assert property (@(posedge clk_sys) disable iff (sys_rst)
    !pwm_in_b |=> !pwm_out_b)
    else $error("output b not low one cycle after input low");

  a_first_load_b: assert property (@(posedge clk_sys) disable iff (sys_rst)
    s_rise_b |=> (r_reg.os_cnt[1] == 8'(({4'h0, $past(first_pulse_width)} + 8'h01) * 8)))
    else $error("first pulse b length not eight per step");

  a_first_high_b: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (s_rise_b or s_hold_b) |=> pwm_out_b)
    else $error("output b low inside first pulse");

  a_chop_gap_b: assert property (@(posedge clk_sys) disable iff (sys_rst)
    ##1 (on_d && in_d[1] && !car_d && (r_reg.os_cnt[1] == 8'h00)) |-> !pwm_out_b)
    else $error("output b high outside carrier pulse");

  // End of the first pulse and its countdown on channel a, idle clear on both channels
  sequence s_pulse_last_a;
    chopper_on && pwm_in_a && r_reg.pwm_prev[0] && (r_reg.os_cnt[0] == 8'h01);
  endsequence

  sequence s_counting_a;
    pwm_in_a && r_reg.pwm_prev[0] && (r_reg.os_cnt[0] != 8'h00);
  endsequence

  a_first_end: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (s_pulse_last_a ##0 !carrier) |=> !pwm_out_a)
    else $error("first pulse a runs past its length");

  a_count_down: assert property (@(posedge clk_sys) disable iff (sys_rst)
    s_counting_a |=> (r_reg.os_cnt[0] == $past(r_reg.os_cnt[0]) - 8'h01))
    else $error("first pulse a count not stepping down");

  a_idle_clear: assert property (@(posedge clk_sys) disable iff (sys_rst)
    !pwm_in_a |=> (r_reg.os_cnt[0] == 8'h00))
    else $error("first pulse a count kept while input low");

  a_idle_clear_b: assert property (@(posedge clk_sys) disable iff (sys_rst)
    !pwm_in_b |=> (r_reg.os_cnt[1] == 8'h00))
    else $error("first pulse b count kept while input low");

  // Bus side: readback, byte lanes, read-only status
  sequence s_ctrl_setup;
    psel && !penable && hit_ctrl;
  endsequence

  sequence s_ctrl_access;
    psel && penable && pwrite && hit_ctrl;
  endsequence

  a_read_ctrl: assert property (@(posedge clk_sys) disable iff (sys_rst)
    s_ctrl_setup |=> ((prdata == {16'h0000, $past(r_reg.ctrl)}) && !pslverr))
    else $error("control readback differs from register");

  a_lane_keep_hi: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (s_ctrl_access ##0 !pstrb[1]) |=> (r_reg.ctrl[15:8] == $past(r_reg.ctrl[15:8])))
    else $error("upper control byte written without its lane");

  a_lane_keep_lo: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (s_ctrl_access ##0 !pstrb[0]) |=> (r_reg.ctrl[7:0] == $past(r_reg.ctrl[7:0])))
    else $error("lower control byte written without its lane");

  a_stat_readonly: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (psel && penable && pwrite && hit_stat) |=> (r_reg.ctrl == $past(r_reg.ctrl)))
    else $error("status write changed the control register");

endmodule

`default_nettype wire

/* File: hw/pcc_consts.svh */
`ifndef PCC_CONSTS_SVH
`define PCC_CONSTS_SVH

// Register indices; byte address is four times the index
`define PCC_CTRL_IDX 12'h01E
`define PCC_STAT_IDX 12'h01F

// Control register layout
`define PCC_CTRL_W 16
`define PCC_CTRL_RST 16'h0000
`define PCC_ON_BIT 0
`define PCC_FPW_LSB 1
`define PCC_FPW_MSB 4
`define PCC_FREQ_LSB 5
`define PCC_FREQ_MSB 7
`define PCC_DUTY_LSB 8
`define PCC_DUTY_MSB 10

// Status register layout
`define PCC_ST_OUT_A 0
`define PCC_ST_OUT_B 1
`define PCC_ST_CARRIER 2
`define PCC_ST_OS_A 3
`define PCC_ST_OS_B 4

// First pulse step: 80 ns at a 10 ns reference clock gives 8 clocks per code
`define PCC_REF_PERIOD_NS 10
`define PCC_FP_STEP_NS_REF 80
`define PCC_FP_CLKS (`PCC_FP_STEP_NS_REF / `PCC_REF_PERIOD_NS)

// Carrier shape: eight phases per period, highest legal duty code
`define PCC_LAST_EIGHTH 3'h7
`define PCC_DUTY_MAX 3'h6

`endif

/* File: hw/pcc_pkg.sv */
`default_nettype none

package pcc_pkg;

  // Carrier generator state
  typedef struct packed {
    logic [2:0] pre_cnt;
    logic [2:0] eighth;
    logic carrier;
  } pcc_car_s;

  // Chopper and bus slave state
  typedef struct packed {
    logic [15:0] ctrl;
    logic [1:0] pwm_prev;
    logic [1:0][7:0] os_cnt;
    logic [1:0] out;
    logic [31:0] prdata;
    logic pslverr;
  } pcc_chop_s;

endpackage

`default_nettype wire

/* File: tb/pcc_gate_drv.sv */
`default_nettype none

module pcc_gate_drv (
  // Clock and counter clear
  input wire logic clk_sys,
  input wire logic clr,
  // Gate drive from the chopper
  input wire logic drv_a,
  input wire logic drv_b,
  // Energised cycles seen by each transformer
  output int on_a,
  output int on_b
);
  timeunit 1ns;
  timeprecision 1ns;

  // Count clocks with the primary energised
  always_ff @(posedge clk_sys) begin
    if (clr) begin
      on_a <= 0;
      on_b <= 0;
    end else begin
      on_a <= on_a + int'(drv_a);
      on_b <= on_b + int'(drv_b);
    end
  end
endmodule

`default_nettype wire

/* File: tb/testbench.sv */
`include "pcc_consts.svh"
`default_nettype none

module testbench;
  timeunit 1ns;
  timeprecision 1ns;

  localparam logic [11:0] CTRL_ADDR = 12'(`PCC_CTRL_IDX << 2);
  logic clk_sys, sys_rst, psel, penable, pwrite, pready, pslverr, perr, clr;
  logic pwm_in_a, pwm_in_b, pwm_out_a, pwm_out_b;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, w;
  logic [3:0] pstrb;
  logic [1:0] last, v, pwm_out;
  int on_a, on_b, err_count, tests_run, n, wd, f;

  assign pwm_out = {pwm_out_a, pwm_out_b};

  pcc_chopper pcc_chopper_i (.clk_sys(clk_sys), .sys_rst(sys_rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .pwm_in_a(pwm_in_a),
    .pwm_in_b(pwm_in_b), .pwm_out_a(pwm_out_a), .pwm_out_b(pwm_out_b));

  pcc_gate_drv pcc_gate_drv_i (.clk_sys(clk_sys), .clr(clr), .drv_a(pwm_out_a),
    .drv_b(pwm_out_b), .on_a(on_a), .on_b(on_b));

  // Clock
  initial begin
    clk_sys = 1'h0;
    forever #20 clk_sys = ~clk_sys;
  end

  // Verdict and end of run
  task automatic report_and_stop();
    $display("Comparisons %0d, mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // Compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One APB transfer, waiting for pready under a bound
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'h1;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
      if (n > 20) begin
        err_count++;
        report_and_stop();
      end
    end while (pready !== 1'h1);
    rd = prdata;
    perr = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask

  // High clocks over two carrier periods; the full-duty code clamps
  function automatic logic [31:0] exp_hi(input int fs, input int ds);
    return 32'(2 * (fs + 1) * ((ds > 6 ? 6 : ds) + 1));
  endfunction

  // Main sequence
  initial begin
    sys_rst = 1'h1;
    psel = 1'h0;
    penable = 1'h0;
    pwrite = 1'h0;
    paddr = 12'h0;
    pwdata = 32'h0;
    pstrb = 4'hF;
    pwm_in_a = 1'h0;
    pwm_in_b = 1'h0;
    clr = 1'h0;
    err_count = 0;
    tests_run = 0;
    n = $urandom(32'h0548);
    repeat (5) @(posedge clk_sys);
    sys_rst <= 1'h0;
    // Reset value, unmapped place, readback
    apb(1'h0, CTRL_ADDR, 32'h0);
    chk(rd, 32'h0);
    apb(1'h0, 12'h040, 32'h0);
    chk({perr, rd[30:0]}, 32'h80000000);
    apb(1'h0, 12'(`PCC_STAT_IDX << 2), 32'h0);
    chk(rd & 32'hFFFF_FFFB, 32'h0);
    w = $urandom;
    apb(1'h1, CTRL_ADDR, w);
    apb(1'h0, CTRL_ADDR, 32'h0);
    chk(rd, {16'h0, w[15:0]});
    // Upper lane only, then a short reset in mid-run
    pstrb <= 4'h2;
    apb(1'h1, CTRL_ADDR, ~w);
    pstrb <= 4'hF;
    apb(1'h0, CTRL_ADDR, 32'h0);
    chk(rd, {16'h0, ~w[15:8], w[7:0]});
    sys_rst <= 1'h1;
    @(posedge clk_sys);
    sys_rst <= 1'h0;
    apb(1'h0, CTRL_ADDR, 32'h0);
    chk(rd, 32'h0);
    // Bypass with the other fields set
    apb(1'h1, CTRL_ADDR, w & 32'hFFFE);
    last = 2'h0;
    for (int i = 0; i < 60; i++) begin
      @(posedge clk_sys);
      v = 2'($urandom);
      {pwm_in_a, pwm_in_b} <= v;
      @(negedge clk_sys);
      chk(32'(pwm_out), 32'(last));
      last = v;
    end
    // First pulse at shortest, longest and random width
    for (int k = 0; k < 3; k++) begin
      wd = (k == 0) ? 0 : (k == 1) ? 15 : int'($urandom % 16);
      @(posedge clk_sys);
      {pwm_in_a, pwm_in_b} <= 2'h0;
      apb(1'h1, CTRL_ADDR, ($urandom & 32'h7E0) | 32'(wd << 1) | 32'h1);
      @(posedge clk_sys);
      {pwm_in_a, pwm_in_b} <= 2'h3;
      @(negedge clk_sys);
      chk(32'(pwm_out), 32'h0);
      repeat (8 * (wd + 1)) begin
        @(negedge clk_sys);
        chk(32'(pwm_out), 32'h3);
      end
      @(posedge clk_sys);
      {pwm_in_a, pwm_in_b} <= 2'h0;
      repeat (2) @(negedge clk_sys);
      chk(32'(pwm_out), 32'h0);
    end
    // Sustaining duty, every code with a random carrier rate
    for (int d = 0; d < 8; d++) begin
      f = int'($urandom % 8);
      apb(1'h1, CTRL_ADDR, 32'((d << 8) | (f << 5) | 1));
      @(posedge clk_sys);
      {pwm_in_a, pwm_in_b} <= 2'h3;
      repeat (12) @(posedge clk_sys);
      clr <= 1'h1;
      @(posedge clk_sys);
      clr <= 1'h0;
      repeat (16 * (f + 1)) @(posedge clk_sys);
      @(negedge clk_sys);
      chk(32'(on_a), exp_hi(f, d));
      chk(32'(on_b), exp_hi(f, d));
      @(posedge clk_sys);
      {pwm_in_a, pwm_in_b} <= 2'h0;
    end
    report_and_stop();
  end
endmodule

`default_nettype wire
